// [core/drs_reset_seq.sv]
// reset pin filter, settings reload and blanking sequencer of the display
module drs_reset_seq
    import drs_pkg::*;
#(
    parameter int RT_IN_CYC = RT_SLEEP_IN_CYC,
    parameter int RT_OUT_CYC = RT_SLEEP_OUT_CYC,
    parameter int BLANK_CYC = BLANK_SEQ_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic hw_reset_n,
    input wire logic sleep_out_mode,
    input wire logic display_enable,
    input wire logic nvm_load_done,
    output drs_out_t drs_out
);

    drs_state_t q_reg;
    drs_state_t q_next;

    localparam logic [FLT_W-1:0] FLT_LAST = FLT_W'(REJECT_CYC - 1);
    // release is seen one filter window late, so the limit is shortened
    localparam int REL_LAG = REJECT_CYC;

    logic [TMR_W-1:0] limit;
    logic load_ok;

    // completion limit depends on the mode captured when reset began
    always_comb begin
        if (q_reg.sleep_out_cap) begin
            limit = TMR_W'(RT_OUT_CYC - REL_LAG - 1);
        end else begin
            limit = TMR_W'(RT_IN_CYC - REL_LAG - 1);
        end
        load_ok = q_reg.nvm_seen || nvm_load_done;
    end

    // next-state logic
    always_comb begin
        q_next = q_reg;
        // pin crosses in through two flops; only sync2 is read below
        q_next.sync1 = hw_reset_n;
        q_next.sync2 = q_reg.sync1;
        q_next.o.defaults_apply = 1'b0;
        unique case (q_reg.st)
            DRS_IDLE: begin
                q_next.o.display_blank = ~display_enable;
                if (!q_reg.sync2) begin
                    q_next.flt_cnt = q_reg.flt_cnt + FLT_W'(1);
                    // accepted at 5us, so every pulse past 9us resets
                    if (q_reg.flt_cnt == FLT_LAST) begin
                        q_next.st = DRS_HELD;
                        q_next.flt_cnt = '0;
                        q_next.sleep_out_cap = sleep_out_mode;
                        q_next.o.display_blank = 1'b1;
                        q_next.o.reset_busy = 1'b1;
                        q_next.o.ready = 1'b0;
                        q_next.o.defaults_apply = 1'b1;
                    end
                end else begin
                    q_next.flt_cnt = '0; // short low pulse dropped
                end
            end
            DRS_HELD: begin
                q_next.o.defaults_apply = 1'b1;
                q_next.o.display_blank = 1'b1;
                if (q_reg.sync2) begin
                    q_next.flt_cnt = q_reg.flt_cnt + FLT_W'(1);
                    if (q_reg.flt_cnt == FLT_LAST) begin
                        q_next.st = DRS_LOAD;
                        q_next.flt_cnt = '0;
                        q_next.timer = '0;
                        q_next.nvm_seen = 1'b0;
                        q_next.o.nvm_load_req = 1'b1;
                    end
                end else begin
                    // a high glitch inside the held reset is ignored
                    q_next.flt_cnt = '0;
                end
            end
            DRS_LOAD: begin
                q_next.o.display_blank = 1'b1;
                q_next.timer = q_reg.timer + TMR_W'(1);
                if (nvm_load_done) begin
                    q_next.nvm_seen = 1'b1;
                    q_next.o.nvm_load_req = 1'b0;
                end
                // low samples keep counting into idle, so a pulse that
                // spans a forced end is not shortened by the hand-over
                if (!q_reg.sync2) begin
                    q_next.flt_cnt = q_reg.flt_cnt + FLT_W'(1);
                end else begin
                    q_next.flt_cnt = '0;
                end
                if (!q_reg.sync2 && q_reg.flt_cnt == FLT_LAST) begin
                    // a fresh valid pulse restarts the reset but keeps the sleep mode captured before
                    q_next.st = DRS_HELD;
                    q_next.flt_cnt = '0;
                    q_next.o.nvm_load_req = 1'b0;
                    q_next.o.defaults_apply = 1'b1;
                end else if ((q_reg.sync2 && load_ok &&
                        (!q_reg.sleep_out_cap ||
                         q_reg.timer >= TMR_W'(BLANK_CYC - REL_LAG)))
                        || q_reg.timer >= limit) begin
                    // sleep-in needs only the load; sleep-out also waits
                    // out the blanking sequence; the limit ends it even
                    // while a short low glitch is still being filtered
                    q_next.st = DRS_IDLE;
                    q_next.o.nvm_load_req = 1'b0;
                    q_next.o.defaults_apply = 1'b1;
                    q_next.o.reset_busy = 1'b0;
                    q_next.o.ready = 1'b1;
                end
            end
            default: begin
                q_next = DRS_RESET_STATE;
            end
        endcase
    end

    // state register; the run counters below only feed the checks
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q_reg <= DRS_RESET_STATE;
        end else begin
            q_reg <= q_next;
        end
    end

    assign drs_out = q_reg.o;

    // helper run-length counters on the synced pin, for checking only
    logic [FLT_W-1:0] low_run;
    logic [FLT_W-1:0] high_run;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            low_run <= '0;
            high_run <= '0;
        end else begin
            low_run <= q_reg.sync2 ? '0 :
                (&low_run ? low_run : low_run + FLT_W'(1));
            high_run <= !q_reg.sync2 ? '0 :
                (&high_run ? high_run : high_run + FLT_W'(1));
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    short_low_rej_a: assert property (
        q_reg.st == DRS_IDLE ##1 q_reg.st == DRS_HELD
        |-> $past(low_run) >= FLT_LAST)
        else $error("reset accepted on a short low pulse");
    long_low_acc_a: assert property (
        low_run >= FLT_W'(FULL_RESET_CYC) |-> q_reg.st == DRS_HELD)
        else $error("long low pulse did not reset");
    held_glitch_a: assert property (
        q_reg.st == DRS_HELD ##1 q_reg.st == DRS_LOAD
        |-> $past(high_run) >= FLT_LAST)
        else $error("short high glitch ended the reset");
    reload_req_a: assert property (
        $rose(q_reg.st == DRS_LOAD) |-> drs_out.nvm_load_req
        ##1 (drs_out.nvm_load_req || $past(nvm_load_done)))
        else $error("settings reload not requested on release");
    blank_busy_a: assert property (
        drs_out.reset_busy |-> drs_out.display_blank)
        else $error("display not blanked during reset");
    defaults_held_a: assert property (
        q_reg.st == DRS_HELD |-> drs_out.defaults_apply)
        else $error("defaults not applied while reset held");
    done_bound_a: assert property (
        q_reg.st == DRS_LOAD |-> q_reg.timer <= limit)
        else $error("reset completion exceeded its limit");
    ready_idle_a: assert property (
        $rose(drs_out.ready) |-> q_reg.st == DRS_IDLE && !drs_out.reset_busy)
        else $error("ready raised outside idle");
    // a held reset stays busy and not ready for its whole length
    held_busy_a: assert property (
        q_reg.st == DRS_HELD |-> drs_out.reset_busy && !drs_out.ready)
        else $error("reset held without busy");
    load_blank_a: assert property (
        q_reg.st == DRS_LOAD |-> drs_out.display_blank && !drs_out.ready)
        else $error("display shown during reload");
    req_drop_a: assert property (
        q_reg.st == DRS_LOAD && nvm_load_done |=> !drs_out.nvm_load_req)
        else $error("reload request kept after done");
    idle_ready_a: assert property (
        q_reg.st == DRS_IDLE |-> drs_out.ready && !drs_out.reset_busy)
        else $error("idle without ready");
    // completion always comes with the defaults pulse
    done_defaults_a: assert property (
        $rose(drs_out.ready) |-> drs_out.defaults_apply)
        else $error("completion without defaults");
    // a sleep-in reset never waits out the blanking sequence
    sleep_in_end_a: assert property (
        q_reg.st == DRS_LOAD && !q_reg.sleep_out_cap
        |-> q_reg.timer <= TMR_W'(RT_IN_CYC - REL_LAG - 1))
        else $error("sleep-in reset overran its limit");
    // a sleep-out reset keeps the panel blank for the blanking sequence
    blank_seq_a: assert property (
        q_reg.st == DRS_LOAD && q_reg.sleep_out_cap
        && q_reg.timer < TMR_W'(BLANK_CYC - REL_LAG)
        |=> q_reg.st != DRS_IDLE)
        else $error("blanking sequence cut short");

    held_c: cover property (q_reg.st == DRS_HELD ##1 q_reg.st == DRS_LOAD);
    glitch_c: cover property (q_reg.st == DRS_HELD && q_reg.sync2
        ##1 !q_reg.sync2);
    sleep_out_c: cover property (q_reg.sleep_out_cap && $rose(drs_out.ready));
    restart_c: cover property (q_reg.st == DRS_LOAD ##1 q_reg.st == DRS_HELD);
    sleep_in_c: cover property (!q_reg.sleep_out_cap && $rose(drs_out.ready));

endmodule

// [common/drs_pkg.sv]
// shared constants and types for the display reset sequencer
package drs_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 10;
    // pulse filter thresholds (ns)
    localparam int REJECT_NS = 5000;
    localparam int FULL_RESET_NS = 9000;
    // release limits per sleep mode (ms)
    localparam int RT_SLEEP_IN_MS = 5;
    localparam int RT_SLEEP_OUT_MS = 120;
    // blanking sequence length in sleep-out mode (ms), within the limit
    localparam int BLANK_SEQ_MS = 100;
    // least times round up
    localparam int REJECT_CYC = (REJECT_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int FULL_RESET_CYC = (FULL_RESET_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // longest times round down
    localparam int RT_SLEEP_IN_CYC = RT_SLEEP_IN_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RT_SLEEP_OUT_CYC = RT_SLEEP_OUT_MS * 1000000
        / CLK_PERIOD_NS;
    localparam int BLANK_SEQ_CYC = BLANK_SEQ_MS * 1000000 / CLK_PERIOD_NS;
    // counter widths
    localparam int FLT_W = 10;
    localparam int TMR_W = 24;

    typedef enum logic [1:0] {
        DRS_IDLE = 2'b00,
        DRS_HELD = 2'b01,
        DRS_LOAD = 2'b10
    } drs_phase_t;

    // outputs toward the rest of the controller
    typedef struct packed {
        logic display_blank;
        logic nvm_load_req;
        logic defaults_apply;
        logic reset_busy;
        logic ready;
    } drs_out_t;

    // whole state of the sequencer
    typedef struct packed {
        drs_phase_t st;
        logic sync1;
        logic sync2;
        logic [FLT_W-1:0] flt_cnt;
        logic [TMR_W-1:0] timer;
        logic sleep_out_cap;
        logic nvm_seen;
        drs_out_t o;
    } drs_state_t;

    // reset value: behaves like a freshly released pin reset
    localparam drs_state_t DRS_RESET_STATE = '{
        st: DRS_LOAD, sync1: 1'b1, sync2: 1'b1, flt_cnt: '0, timer: '0,
        sleep_out_cap: 1'b0, nvm_seen: 1'b0,
        o: '{display_blank: 1'b1, nvm_load_req: 1'b1, defaults_apply: 1'b1,
             reset_busy: 1'b1, ready: 1'b0}
    };
endpackage

// [sim/drs_host_model.sv]
// host side model: drives the reset pin and tracks command wait times
module drs_host_model #(
    parameter int CMD_WAIT = 2000,
    parameter int WAKE_WAIT = 6000
) (
    input wire logic core_clk,
    output logic hw_reset_n,
    output logic cmd_ok,
    output logic wake_ok
);
    timeunit 1ns;
    timeprecision 100ps;
    int since_rel = 0;
    initial hw_reset_n = 1'b1;
    // cycles since the pin last rose, saturating so it never wraps
    always @(posedge core_clk) begin
        if (!hw_reset_n) since_rel <= 0;
        else if (since_rel < WAKE_WAIT) since_rel <= since_rel + 1;
    end
    assign cmd_ok = hw_reset_n && since_rel >= CMD_WAIT;
    assign wake_ok = hw_reset_n && since_rel >= WAKE_WAIT;
    // one low pulse counted in clock cycles, moved just after an edge
    task automatic pulse(input int low_cyc);
        @(posedge core_clk);
        #1 hw_reset_n = 1'b0;
        repeat (low_cyc) @(posedge core_clk);
        #1 hw_reset_n = 1'b1;
    endtask
endmodule

// [sim/tb_top.sv]
// self-checking bench for the display reset sequencer
module tb_top
    import drs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RT_IN = 2000;
    localparam int RT_OUT = 6000;
    localparam int BLK = 4000;
    logic core_clk = 1'b0, rstn, sleep_out_mode, display_enable;
    logic nvm_load_done, hw_reset_n, cmd_ok, wake_ok;
    drs_out_t drs_out;
    int err_count = 0, n_tests = 0, cyc = 0;

    drs_reset_seq #(.RT_IN_CYC(RT_IN), .RT_OUT_CYC(RT_OUT),
        .BLANK_CYC(BLK)) drs_reset_seq_i (.core_clk(core_clk), .rstn(rstn),
        .hw_reset_n(hw_reset_n), .sleep_out_mode(sleep_out_mode),
        .display_enable(display_enable), .nvm_load_done(nvm_load_done),
        .drs_out(drs_out));
    // waits padded a little for the pin synchroniser
    drs_host_model #(.CMD_WAIT(RT_IN + 20), .WAKE_WAIT(RT_OUT + 20))
        drs_host_model_i (.core_clk(core_clk), .hw_reset_n(hw_reset_n),
        .cmd_ok(cmd_ok), .wake_ok(wake_ok));

    always #5 core_clk = ~core_clk;
    // hang guard, well above the roughly 20k cycles the run needs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %b got %b", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // a valid 10us pulse; at release the filter still holds the reset
    task automatic full_reset(input logic so);
        sleep_out_mode = so;
        drs_host_model_i.pulse(1000);
        chk("busy held", 1'b1, drs_out.reset_busy);
        chk("blank held", 1'b1, drs_out.display_blank);
        chk("defaults held", 1'b1, drs_out.defaults_apply);
        chk("ready held", 1'b0, drs_out.ready);
        tick(600);
        chk("reload req", 1'b1, drs_out.nvm_load_req);
    endtask

    task automatic load_done();
        nvm_load_done = 1'b1;
        tick(1);
        nvm_load_done = 1'b0;
        tick(2);
        chk("req dropped", 1'b0, drs_out.nvm_load_req);
    endtask

    task automatic s_reject();
        drs_host_model_i.pulse(300);
        tick(700);
        chk("busy short", 1'b0, drs_out.reset_busy);
        chk("ready short", 1'b1, drs_out.ready);
        // in idle the blanking follows the display enable
        display_enable = 1'b0;
        tick(2);
        chk("blank off", 1'b1, drs_out.display_blank);
        display_enable = 1'b1;
        tick(2);
        chk("blank on", 1'b0, drs_out.display_blank);
    endtask

    task automatic s_sleep_in();
        full_reset(1'b0);
        load_done();
        chk("ready in", 1'b1, drs_out.ready);
        chk("blank idle", 1'b0, drs_out.display_blank);
    endtask

    // a 200 cycle high inside a held reset must not start the reload
    task automatic s_glitch();
        drs_host_model_i.pulse(1000);
        tick(200);
        fork
            drs_host_model_i.pulse(800);
            begin
                tick(450);
                chk("req glitch", 1'b0, drs_out.nvm_load_req);
            end
        join
        tick(600);
        load_done();
        chk("ready glitch", 1'b1, drs_out.ready);
    endtask

    // early reload done must not cut the blanking sequence short
    task automatic s_sleep_out();
        full_reset(1'b1);
        load_done();
        tick(2500);
        chk("ready early", 1'b0, drs_out.ready);
        for (int i = 0; i < 4000 && wake_ok !== 1'b1; i++) tick(1);
        chk("ready out", 1'b1, drs_out.ready);
        sleep_out_mode = 1'b0;
    endtask

    // no reload done: completion is forced within the sleep-in limit
    task automatic s_timeout();
        full_reset(1'b0);
        for (int i = 0; i < 3000 && cmd_ok !== 1'b1; i++) tick(1);
        chk("ready forced", 1'b1, drs_out.ready);
    endtask

    // a second valid pulse during the reload restarts the reset
    task automatic s_restart();
        full_reset(1'b0);
        drs_host_model_i.pulse(1000);
        chk("req restart", 1'b0, drs_out.nvm_load_req);
        chk("busy restart", 1'b1, drs_out.reset_busy);
        chk("ready restart", 1'b0, drs_out.ready);
        tick(600);
        chk("req again", 1'b1, drs_out.nvm_load_req);
        load_done();
        chk("ready again", 1'b1, drs_out.ready);
    endtask

    initial begin
        rstn = 1'b0;
        sleep_out_mode = 1'b0;
        display_enable = 1'b1;
        nvm_load_done = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rstn = 1'b1;
        tick(RT_IN + 10);
        chk("ready start", 1'b1, drs_out.ready);
        s_reject();
        s_sleep_in();
        s_glitch();
        s_sleep_out();
        s_timeout();
        s_restart();
        wrap_up();
    end
endmodule
